// ---- shared/sspc_pkg.sv ----
/*
  sspc_pkg: register map, field layout and format codes of the serial port
  programming interface.
  assumes: APB with 32-bit data; 12 address bits are decoded.
*/
package sspc_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL0   = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] DATA_BASE    = 12'h020;
  // upper address bits that select the eight-word data window
  localparam logic [11:0] DATA_MASK    = 12'hfe0;
  // control register 0 fields
  localparam int WLS_LSB   = 0;
  localparam int WLS_W     = 4;
  localparam int FSS_LSB   = 4;
  localparam int FSS_W     = 2;
  localparam int EN_POS    = 7;
  localparam int RATE_LSB  = 8;
  localparam int RATE_W    = 8;
  // status register fields
  localparam int ST_TX_REQ = 0;
  localparam int ST_RX_REQ = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_TNF    = 3;
  localparam int ST_RNE    = 4;
  localparam int ST_ROR    = 5;
  localparam int ST_TXLVL  = 8;
  localparam int ST_RXLVL  = 16;
  localparam int LVL_W     = 5;
  // frame style codes
  localparam logic [1:0] FMT_SPI   = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_CMD   = 2'h2;
  // command/response framing
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] RESP_GAP  = 5'h01;
  // lane width used in the fifos
  localparam int WORD_W    = 16;
  // pin slots: clock, frame, transmit data, receive data
  localparam int PIN_CLK   = 0;
  localparam int PIN_FRM   = 1;
  localparam int PIN_TXD   = 2;
  localparam int PIN_RXD   = 3;
  typedef enum logic [1:0] {SSPC_IDLE, SSPC_SYNC, SSPC_BITS} sspc_state_t;
endpackage

// ---- design/sspc_top.sv ----
/*
  sspc_top: control register 0, status, data window, transmit and receive
  fifos and the serial engine of a four-pin synchronous serial port.
  assumes: ref_tick is a one-cycle pulse at the 3.6864 MHz reference rate,
  synchronous to core_clk; the gpio block supplies pin values while the port
  is disabled or asleep.
*/
// What this block does
// - eight-word data window, writes tx, reads rx
// - only low sixteen bits carry data
// - low three word-address bits ignored
// - separate independent tx and rx fifos
// - status shows requests, levels, busy, flags, overrun
// - received words right-justified, zero-filled
// - tx bits above word length ignored
// - command format sends eight-bit command
// - two-bit frame style select in 5:4
// - enable bit gates all port operation
// - reset clears enable and all other fields
// - disable aborts frame and flushes fifos
// - disabled or asleep pins follow gpio
// - serial clock divided from reference
// - drive one edge, sample the other
// - bit 6 ignores writes, reads zero
// - rate field 15:8, ref over 2(n+1)
// - enable at bit 7, 31:16 reserved
`timescale 1ns/1ps
module sspc_top #(
  parameter int DEPTH     = 16,
  parameter int TX_THRESH = 8,
  parameter int RX_THRESH = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ref_tick,
  input  wire logic        sleep_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  pin_in,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe
);
  localparam int AW = $clog2(DEPTH);
  localparam int W  = sspc_pkg::WORD_W;

  function automatic logic [AW:0] level(input logic [AW:0] wp, input logic [AW:0] rp);
    level = wp - rp;
  endfunction

  function automatic logic in_window(input logic [11:0] a);
    in_window = (a & sspc_pkg::DATA_MASK) == sspc_pkg::DATA_BASE;
  endfunction

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // control register 0
  logic [3:0] word_length_select;
  logic [1:0] frame_style_select;
  logic       port_enable_bit;
  logic [7:0] bit_rate_divisor;
  logic       ror_flag;

  logic access;
  logic wr_go;
  logic rd_go;
  assign access = psel && penable && pready;
  assign wr_go  = access && pwrite;
  assign rd_go  = access && !pwrite;

  // the write that clears enable flushes on its own edge, so no stale level is read
  logic port_on;
  assign port_on = port_enable_bit
                   && !(wr_go && paddr == sspc_pkg::ADDR_CTRL0 && !pwdata[sspc_pkg::EN_POS]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_enable_bit <= 1'b0;
    end else if (wr_go && paddr == sspc_pkg::ADDR_CTRL0) begin
      port_enable_bit <= pwdata[sspc_pkg::EN_POS];
    end
  end

  // other fields reset to zero only to keep simulation defined
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_length_select <= 4'h0;
      frame_style_select <= 2'h0;
      bit_rate_divisor   <= 8'h00;
    end else if (wr_go && paddr == sspc_pkg::ADDR_CTRL0) begin
      word_length_select <= pwdata[sspc_pkg::WLS_LSB +: sspc_pkg::WLS_W];
      frame_style_select <= pwdata[sspc_pkg::FSS_LSB +: sspc_pkg::FSS_W];
      bit_rate_divisor   <= pwdata[sspc_pkg::RATE_LSB +: sspc_pkg::RATE_W];
    end
  end

  // fifos: separate storage and pointers, so both ends run at once
  logic [W-1:0] tx_mem [DEPTH];
  logic [W-1:0] rx_mem [DEPTH];
  logic [AW:0]  tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0]  tx_lvl, rx_lvl;
  logic         tx_full, tx_empty, rx_full, rx_empty;
  logic         tx_pop, rx_push;
  logic [W-1:0] rx_word;
  assign tx_lvl   = level(tx_wp, tx_rp);
  assign rx_lvl   = level(rx_wp, rx_rp);
  assign tx_full  = tx_lvl == (AW+1)'(DEPTH);
  assign rx_full  = rx_lvl == (AW+1)'(DEPTH);
  assign tx_empty = tx_lvl == '0;
  assign rx_empty = rx_lvl == '0;

  logic tx_push;
  logic rx_pop;
  assign tx_push = wr_go && in_window(paddr) && !tx_full;
  assign rx_pop  = rd_go && in_window(paddr) && !rx_empty;

  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp[AW-1:0]] <= pwdata[W-1:0];
    end
    if (rx_push && !rx_full) begin
      rx_mem[rx_wp[AW-1:0]] <= rx_word;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp <= '0;
      tx_rp <= '0;
    end else if (!port_on) begin
      tx_wp <= '0;
      tx_rp <= '0;
    end else begin
      if (tx_push) begin
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp <= '0;
      rx_rp <= '0;
    end else if (!port_on) begin
      rx_wp <= '0;
      rx_rp <= '0;
    end else begin
      if (rx_push && !rx_full) begin
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 1'b1;
      end
    end
  end

  // bit-rate divider: one half period per (divisor+1) reference ticks
  logic [7:0] rate_cnt;
  logic       half_tick;
  assign half_tick = ref_tick && rate_cnt == bit_rate_divisor;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt <= 8'h00;
    end else if (!port_enable_bit) begin
      rate_cnt <= 8'h00;
    end else if (half_tick) begin
      rate_cnt <= 8'h00;
    end else if (ref_tick) begin
      rate_cnt <= rate_cnt + 8'h01;
    end
  end

  // serial engine
  sspc_pkg::sspc_state_t state;
  logic         half;
  logic [4:0]   bitn;
  logic [W-1:0] tx_sh;
  logic [W-1:0] rx_sh;
  logic [4:0]   wl;
  logic [4:0]   last_bit;
  logic         cmd_fmt;
  logic         pulse_fmt;
  logic         sample_ok;
  logic         frame_end;
  logic         start;
  logic [W-1:0] tx_head;
  logic [W-1:0] tx_load;
  assign wl        = {1'b0, word_length_select} + 5'h01;
  assign cmd_fmt   = frame_style_select == sspc_pkg::FMT_CMD;
  assign pulse_fmt = frame_style_select == sspc_pkg::FMT_PULSE;
  assign last_bit  = cmd_fmt ? sspc_pkg::CMD_BITS + sspc_pkg::RESP_GAP + wl - 5'h01
                             : wl - 5'h01;
  assign sample_ok = !cmd_fmt || bitn >= sspc_pkg::CMD_BITS + sspc_pkg::RESP_GAP;
  assign frame_end = state == sspc_pkg::SSPC_BITS && half_tick && half && bitn == last_bit;
  assign start     = half_tick && !tx_empty
                     && (state == sspc_pkg::SSPC_IDLE || frame_end);
  assign tx_pop    = start;
  assign tx_head   = tx_mem[tx_rp[AW-1:0]];
  // left-align so the msb leaves first; bits above the length fall off
  assign tx_load   = cmd_fmt ? {tx_head[7:0], 8'h00}
                             : tx_head << (5'd16 - wl);
  assign rx_push   = frame_end;
  assign rx_word   = rx_sh;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sspc_pkg::SSPC_IDLE;
      half  <= 1'b0;
      bitn  <= 5'h00;
      tx_sh <= '0;
      rx_sh <= '0;
    end else if (!port_enable_bit) begin
      state <= sspc_pkg::SSPC_IDLE;
      half  <= 1'b0;
      bitn  <= 5'h00;
      tx_sh <= '0;
    end else if (start) begin
      state <= pulse_fmt ? sspc_pkg::SSPC_SYNC : sspc_pkg::SSPC_BITS;
      half  <= 1'b0;
      bitn  <= 5'h00;
      tx_sh <= tx_load;
      rx_sh <= '0;
    end else if (half_tick) begin
      case (state)
        sspc_pkg::SSPC_IDLE: begin
          half <= 1'b0;
        end
        sspc_pkg::SSPC_SYNC: begin
          half <= !half;
          if (half) begin
            state <= sspc_pkg::SSPC_BITS;
          end
        end
        sspc_pkg::SSPC_BITS: begin
          half <= !half;
          if (!half && sample_ok) begin
            rx_sh <= {rx_sh[W-2:0], pin_in[sspc_pkg::PIN_RXD]};
          end
          if (half) begin
            tx_sh <= {tx_sh[W-2:0], 1'b0};
            bitn  <= bitn + 5'h01;
            if (bitn == last_bit) begin
              state <= sspc_pkg::SSPC_IDLE;
            end
          end
        end
        default: begin
          state <= sspc_pkg::SSPC_IDLE;
        end
      endcase
    end
  end

  // receive overrun: sticky, write one to clear, a new event wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ror_flag <= 1'b0;
    end else if (rx_push && rx_full) begin
      ror_flag <= 1'b1;
    end else if (wr_go && paddr == sspc_pkg::ADDR_STATUS && pwdata[sspc_pkg::ST_ROR]) begin
      ror_flag <= 1'b0;
    end
  end

  // pins: engine while enabled and awake, otherwise the gpio block
  logic       serial_clk;
  logic       serial_frm;
  logic       use_gpio;
  assign use_gpio   = !port_enable_bit || sleep_mode;
  // pulse style: clock high in the lead half, drive on rise, sample on fall
  assign serial_clk = state == sspc_pkg::SSPC_BITS && (pulse_fmt ? !half : half);
  assign serial_frm = pulse_fmt ? state == sspc_pkg::SSPC_SYNC
                                : state == sspc_pkg::SSPC_IDLE;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 4'h0;
      pin_oe  <= 4'h0;
    end else if (use_gpio) begin
      pin_out <= gpio_out;
      pin_oe  <= gpio_oe;
    end else begin
      pin_out[sspc_pkg::PIN_CLK] <= serial_clk;
      pin_out[sspc_pkg::PIN_FRM] <= serial_frm;
      // txd holds its last bit through idle
      pin_out[sspc_pkg::PIN_TXD] <= (state == sspc_pkg::SSPC_IDLE)
                                    ? pin_out[sspc_pkg::PIN_TXD] : tx_sh[W-1];
      pin_out[sspc_pkg::PIN_RXD] <= 1'b0;
      pin_oe <= 4'h7;
    end
  end

  // apb slave: data prepared in setup, answered in the first access cycle
  logic [31:0] next_rdata;
  logic        next_err;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr == sspc_pkg::ADDR_CTRL0) begin
      next_rdata[sspc_pkg::WLS_LSB +: sspc_pkg::WLS_W]   = word_length_select;
      next_rdata[sspc_pkg::FSS_LSB +: sspc_pkg::FSS_W]   = frame_style_select;
      next_rdata[sspc_pkg::EN_POS]                       = port_enable_bit;
      next_rdata[sspc_pkg::RATE_LSB +: sspc_pkg::RATE_W] = bit_rate_divisor;
    end else if (paddr == sspc_pkg::ADDR_STATUS) begin
      next_rdata[sspc_pkg::ST_TX_REQ] = port_enable_bit && tx_lvl <= (AW+1)'(TX_THRESH);
      next_rdata[sspc_pkg::ST_RX_REQ] = port_enable_bit && rx_lvl >= (AW+1)'(RX_THRESH);
      next_rdata[sspc_pkg::ST_BUSY]   = state != sspc_pkg::SSPC_IDLE || !tx_empty;
      next_rdata[sspc_pkg::ST_TNF]    = !tx_full;
      next_rdata[sspc_pkg::ST_RNE]    = !rx_empty;
      next_rdata[sspc_pkg::ST_ROR]    = ror_flag;
      next_rdata[sspc_pkg::ST_TXLVL +: sspc_pkg::LVL_W] = sspc_pkg::LVL_W'(tx_lvl);
      next_rdata[sspc_pkg::ST_RXLVL +: sspc_pkg::LVL_W] = sspc_pkg::LVL_W'(rx_lvl);
    end else if (in_window(paddr)) begin
      // empty fifo reads as zero; upper half always zero
      next_rdata[W-1:0] = rx_empty ? '0 : rx_mem[rx_rp[AW-1:0]];
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      if (psel && !penable && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule // sspc_top

// ---- testbench/sspc_top_asserts.sv ----
/*
  sspc_top_asserts: port checker for sspc_top.
  assumes: bound into sspc_top; one clock; the bus master keeps apb order.
*/
`timescale 1ns/1ps
module sspc_top_asserts #(
  parameter int DEPTH     = 16,
  parameter int TX_THRESH = 8,
  parameter int RX_THRESH = 8
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        ref_tick,
  input wire logic        sleep_mode,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  pin_in,
  input wire logic [3:0]  gpio_out,
  input wire logic [3:0]  gpio_oe,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe
);
  logic [15:0] cfg;
  logic [1:0]  lv;
  logic        off;
  logic        mapped;
  assign off    = !cfg[sspc_pkg::EN_POS] || sleep_mode;
  assign mapped = paddr == sspc_pkg::ADDR_CTRL0 || paddr == sspc_pkg::ADDR_STATUS
                  || (paddr & sspc_pkg::DATA_MASK) == sspc_pkg::DATA_BASE;
  // bus-side mirror; lv masks the edges of the internal reset sync
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= 16'h0000;
      lv  <= 2'h0;
    end else begin
      if (lv != 2'h3) lv <= lv + 2'h1;
      if (pready && pwrite && paddr == sspc_pkg::ADDR_CTRL0) cfg <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  AST_ZERO_WAIT: assert property (s_setup |=> pready)
    else $error("no zero-wait answer");
  AST_READY_PULSE: assert property (s_access |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (
    pready |-> penable && $past(psel) && !$past(penable)) else $error("ready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_DECODE: assert property (pready |-> pslverr == !mapped)
    else $error("bad address decode");
  AST_CTRL_READBACK: assert property (
    pready && !pwrite && paddr == sspc_pkg::ADDR_CTRL0 |-> prdata == {16'h0000, cfg & 16'hffbf})
    else $error("control readback wrong");
  AST_FLUSH_LEVELS: assert property (
    pready && !pwrite && paddr == sspc_pkg::ADDR_STATUS && !cfg[sspc_pkg::EN_POS]
    |-> prdata[20:16] == 5'h00 && prdata[12:8] == 5'h00) else $error("levels not flushed");
  AST_DISABLED_GPIO: assert property (
    lv == 2'h3 && off && $past(off) |=> pin_out == $past(gpio_out) && pin_oe == $past(gpio_oe))
    else $error("pins not following gpio");
  AST_SPI_IDLE_CLK: assert property (
    !off && !$past(off) && cfg[5:4] == sspc_pkg::FMT_SPI && pin_out[1] |-> !pin_out[0])
    else $error("clock moves outside frame");
endmodule // sspc_top_asserts

bind sspc_top sspc_top_asserts #(
  .DEPTH(DEPTH), .TX_THRESH(TX_THRESH), .RX_THRESH(RX_THRESH)
) u_sspc_top_asserts (
  .core_clk(core_clk), .rstn(rstn), .ref_tick(ref_tick), .sleep_mode(sleep_mode),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe)
);

// ---- testbench/sspc_peer.sv ----
/*
  sspc_peer: serial peripheral, clock idle low, shift on fall, sample on rise.
  assumes: frame active low; len and reply stay put during a frame.
*/
`timescale 1ns/1ps
module sspc_peer (
  input  wire logic        sclk,
  input  wire logic        frame_n,
  input  wire logic        txd,
  input  wire logic [4:0]  len,
  input  wire logic [15:0] reply,
  output logic             rxd
);
  int unsigned got_q[$];
  logic [15:0] sh = 16'h0000;
  int          n  = 0;
  initial rxd = 1'b0;
  always @(negedge frame_n) begin
    n = 0;
    sh = 16'h0000;
    rxd = reply[int'(len) - 1];
  end
  // released line shows the inverse, never a stale bit
  always @(posedge frame_n) rxd = ~rxd;
  always @(posedge sclk) if (!frame_n) begin
    sh = {sh[14:0], txd};
    n = n + 1;
    if (n == int'(len)) begin
      got_q.push_back(sh);
      n = 0;
      sh = 16'h0000;
    end
  end
  always @(negedge sclk) if (!frame_n) rxd = reply[int'(len) - 1 - n];
endmodule // sspc_peer

// ---- testbench/tb.sv ----
/*
  tb: self-checking bench for sspc_top with a serial peer model.
  assumes: ref_tick every third cycle; peer answers each word with reply.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  logic        core_clk = 1'b0, rstn = 1'b0, ref_tick = 1'b0, sleep_mode = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rxd;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, w;
  logic [3:0]  gpio_out = 4'h0, gpio_oe = 4'h0, pin_out, pin_oe, pin_in, code;
  logic [4:0]  len = 5'h08;
  logic [1:0]  fmt;
  int unsigned got;
  logic [15:0] reply = 16'h0000, mask;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  int          txq[$];
  assign pin_in = {pin_oe[3] ? pin_out[3] : rxd, pin_out[2:0]};
  always #5 core_clk = ~core_clk;
  task automatic finish_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ref_tick <= (cyc % 3 == 0);
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  sspc_top u_sspc_top (
    .core_clk(core_clk), .rstn(rstn), .ref_tick(ref_tick), .sleep_mode(sleep_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out), .pin_oe(pin_oe)
  );
  sspc_peer u_sspc_peer (
    .sclk(pin_out[0]), .frame_n(pin_out[1]), .txd(pin_out[2]), .len(len),
    .reply(reply), .rxd(rxd)
  );
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    `CHK(pslverr, err)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    void'($urandom(5086));
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    apb(1'b0, sspc_pkg::ADDR_CTRL0, 32'h0000_0000, 1'b0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 12'h100, $urandom, 1'b1);
    for (int k = 0; k < 3; k++) begin
      w = $urandom;
      w[7:0] = {1'b0, w[6], k[1:0], 4'h3 + k[3:0]};
      apb(1'b1, sspc_pkg::ADDR_CTRL0, w, 1'b0);
      apb(1'b0, sspc_pkg::ADDR_CTRL0, 32'h0000_0000, 1'b0);
      `CHK(rd, w & 32'h0000_ffbf)
    end
    gpio_out <= 4'($urandom);
    gpio_oe <= 4'($urandom);
    repeat (3) @(posedge core_clk);
    `CHK({pin_oe, pin_out}, {gpio_oe, gpio_out})
    // four-bit and sixteen-bit spi words, then command style; three words each
    for (int j = 0; j < 3; j++) begin
      code = (j == 1) ? 4'hf : 4'h3;
      fmt = (j == 2) ? sspc_pkg::FMT_CMD : sspc_pkg::FMT_SPI;
      // command frame: command bits, gap bit, then the reply
      len <= (j == 2) ? sspc_pkg::CMD_BITS + sspc_pkg::RESP_GAP + 5'h04
                      : {1'b0, code} + 5'h01;
      mask = 16'hffff >> (4'hf - code);
      reply <= 16'($urandom);
      apb(1'b1, sspc_pkg::ADDR_CTRL0, {16'h0000, 8'h01, 2'h2, fmt, code}, 1'b0);
      u_sspc_peer.got_q.delete();
      txq.delete();
      for (int k = 0; k < 3; k++) begin
        w = $urandom;
        txq.push_back((j == 2) ? w[7:0] : w & mask);
        apb(1'b1, sspc_pkg::DATA_BASE + 12'(12 * k), w, 1'b0);
      end
      do apb(1'b0, sspc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
      while (rd[2] || rd[20:16] != 5'h03);
      `CHK(rd[4:3], 2'b11)
      for (int k = 0; k < 3; k++) begin
        apb(1'b0, sspc_pkg::DATA_BASE + 12'(4 * (7 - k)), 32'h0000_0000, 1'b0);
        `CHK(rd[15:0], reply & mask)
        got = u_sspc_peer.got_q[k] >> ((j == 2) ? len - sspc_pkg::CMD_BITS : 5'h00);
        `CHK(got, txq[k])
      end
    end
    // seventeen words into the sixteen-deep receive fifo overrun it
    for (int k = 0; k < 17; k++) begin
      apb(1'b1, sspc_pkg::DATA_BASE, $urandom, 1'b0);
    end
    do apb(1'b0, sspc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    while (rd[2]);
    `CHK(rd[20:16], 5'h10)
    `CHK(rd[5:0], 6'h3b)
    apb(1'b1, sspc_pkg::ADDR_STATUS, 32'h0000_0020, 1'b0);
    apb(1'b0, sspc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    `CHK(rd[5], 1'b0)
    apb(1'b1, sspc_pkg::DATA_BASE, 32'h0000_a5a5, 1'b0);
    apb(1'b1, sspc_pkg::DATA_BASE, 32'h0000_5a5a, 1'b0);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK({pin_oe, pin_out}, {gpio_oe, gpio_out})
    sleep_mode <= 1'b0;
    repeat (20) @(posedge core_clk);
    apb(1'b1, sspc_pkg::ADDR_CTRL0, 32'h0000_010f, 1'b0);
    apb(1'b0, sspc_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
    `CHK(rd[20:16], 5'h00)
    `CHK(rd[12:8], 5'h00)
    apb(1'b0, sspc_pkg::ADDR_CTRL0, 32'h0000_0000, 1'b0);
    `CHK(rd, 32'h0000_010f)
    finish_test();
  end
endmodule // tb
